// ==== hdl/qtrc_top.sv ====
// Notes on behaviour
// - A write to the run control register changes a running bit only where its write-enable bit is one.
// - Writing ff starts all four timers, writing f0 changes nothing.
// - Bits 7 to 4 of the run control register read back whether timers 3 to 0 are counting.
// - A masked write of one starts a timer and a masked write of zero stops it.
// - Enable bits 3..0 gate running bits 7..4 and read as zero.
// - With halt on receive set, timer 0 stops once the receiver has taken its first four bits.
// - In an oscillator trimming mode the halt on receive bit is ignored.
// - Start source 00 gives no automatic start, 01 starts timer 0 at the end of a transmission.
// - Start source 10 and 11 trim against the low-frequency oscillator, without and with underflow.
// - With reload on zero set and start source other than 10, timer 0 reloads its preset at zero and keeps counting.
// - With reload on zero clear, timer 0 stops at zero and its running bit drops.
// - Every underflow of timer 0 sets the underflow flag.
// - Clock select 00 counts at 13.56 MHz and 01 at 211.875 kHz.
// - Clock select 10 counts underflows of timer 2 and 11 underflows of timer 1.
// - Each start event and each reload at zero loads the counter from the preset, so preset changes act at the next start or reload.
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/10ps
module qtrc_top #(
   parameter logic [15:0] OTHER_PRESET = 16'h00ff
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic tx_done,
   input wire logic rx_nibble_done,
   input wire logic low_frequency_oscillator,
   output logic irq
);
   logic [31:0] hrdata_reg;
   logic irq_reg;
   logic wr_pend_reg;
   logic [7:0] wr_idx_reg;
   logic [3:0] run_reg;
   logic [7:0] cfg_reg;
   logic [15:0] preset_reg;
   logic [15:0] cnt0_reg;
   logic [15:0] cnt_reg [1:3];
   logic [3:0] uf_reg;
   logic [3:0] status_reg;
   logic [3:0] mask_reg;
   logic [15:0] acc_reg;
   logic fast_tick_reg;
   logic [5:0] slow_cnt_reg;
   logic slow_tick_reg;
   logic [2:0] osc_sync_reg;

   logic [7:0] wdata;
   logic wr_ctrl;
   logic [3:0] sw_start;
   logic [3:0] sw_stop;
   logic trim_mode;
   logic osc_rise;
   logic t0_start;
   logic t0_stop;
   logic halt_ev;
   logic tick0;
   logic uf0_allowed;
   logic [16:0] acc_sum;

   function automatic logic [7:0] reg_index(input logic [31:0] a);
      reg_index = a[9:2];
   endfunction : reg_index

   assign hrdata = hrdata_reg;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign irq = irq_reg;

   // Bus slave: zero wait states, read data prepared at the address phase
   wire addr_phase = hsel && htrans[1] && hready;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_idx_reg <= 8'h00;
      end else begin
         wr_pend_reg <= addr_phase && hwrite;
         wr_idx_reg <= reg_index(haddr);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_reg <= 32'h0000_0000;
      end else if (addr_phase && !hwrite) begin
         case (reg_index(haddr))
            qtrc_pkg::IDX_RUN_CTRL: hrdata_reg <= {24'h000000, run_reg, 4'h0};
            qtrc_pkg::IDX_T0_CFG: hrdata_reg <= {24'h000000, cfg_reg};
            qtrc_pkg::IDX_PRESET_HI: hrdata_reg <= {24'h000000, preset_reg[15:8]};
            qtrc_pkg::IDX_PRESET_LO: hrdata_reg <= {24'h000000, preset_reg[7:0]};
            qtrc_pkg::IDX_COUNT_HI: hrdata_reg <= {24'h000000, cnt0_reg[15:8]};
            qtrc_pkg::IDX_COUNT_LO: hrdata_reg <= {24'h000000, cnt0_reg[7:0]};
            qtrc_pkg::IDX_IRQ_STATUS: hrdata_reg <= {28'h0000000, status_reg};
            qtrc_pkg::IDX_IRQ_MASK: hrdata_reg <= {28'h0000000, mask_reg};
            default: hrdata_reg <= 32'h0000_0000;
         endcase
      end
   end

   assign wdata = hwdata[7:0];
   assign wr_ctrl = wr_pend_reg && (wr_idx_reg == qtrc_pkg::IDX_RUN_CTRL);
   assign sw_start = {4{wr_ctrl}} & wdata[3:0] & wdata[7:4];
   assign sw_stop = {4{wr_ctrl}} & wdata[3:0] & ~wdata[7:4];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_reg <= qtrc_pkg::CFG_RESET;
         preset_reg <= qtrc_pkg::PRESET_RESET;
         mask_reg <= qtrc_pkg::IRQ_RESET;
      end else if (wr_pend_reg) begin
         case (wr_idx_reg)
            qtrc_pkg::IDX_T0_CFG: cfg_reg <= wdata & qtrc_pkg::CFG_WRITABLE;
            qtrc_pkg::IDX_PRESET_HI: preset_reg[15:8] <= wdata;
            qtrc_pkg::IDX_PRESET_LO: preset_reg[7:0] <= wdata;
            qtrc_pkg::IDX_IRQ_MASK: mask_reg <= wdata[3:0];
            default: ;
         endcase
      end
   end

   // Time base: fractional accumulator gives 13.56 MHz ticks on average
   assign acc_sum = {1'b0, acc_reg} + 17'(qtrc_pkg::FAST_KHZ);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         acc_reg <= 16'h0000;
         fast_tick_reg <= 1'b0;
         slow_cnt_reg <= 6'h00;
         slow_tick_reg <= 1'b0;
      end else begin
         if (acc_sum >= 17'(qtrc_pkg::SYS_KHZ)) begin
            acc_reg <= 16'(acc_sum - 17'(qtrc_pkg::SYS_KHZ));
            fast_tick_reg <= 1'b1;
         end else begin
            acc_reg <= acc_sum[15:0];
            fast_tick_reg <= 1'b0;
         end
         slow_tick_reg <= 1'b0;
         if (fast_tick_reg) begin
            if (slow_cnt_reg == 6'(qtrc_pkg::SLOW_DIV - 1)) begin
               slow_cnt_reg <= 6'h00;
               slow_tick_reg <= 1'b1;
            end else begin
               slow_cnt_reg <= slow_cnt_reg + 6'h01;
            end
         end
      end
   end

   // Oscillator pin is asynchronous
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         osc_sync_reg <= 3'h0;
      end else begin
         osc_sync_reg <= {osc_sync_reg[1:0], low_frequency_oscillator};
      end
   end
   assign osc_rise = osc_sync_reg[1] && !osc_sync_reg[2];

   // Timers 1 to 3: fixed preset, free reload, started and stopped by software only
   generate
      for (genvar i = 1; i < 4; i++) begin : g_other
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               cnt_reg[i] <= 16'h0000;
               uf_reg[i] <= 1'b0;
            end else begin
               uf_reg[i] <= 1'b0;
               if (sw_start[i]) begin
                  cnt_reg[i] <= OTHER_PRESET;
               end else if (run_reg[i] && fast_tick_reg) begin
                  if (cnt_reg[i] == 16'h0000) begin
                     cnt_reg[i] <= OTHER_PRESET;
                     uf_reg[i] <= 1'b1;
                  end else begin
                     cnt_reg[i] <= cnt_reg[i] - 16'h0001;
                  end
               end
            end
         end
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               run_reg[i] <= qtrc_pkg::RUN_RESET[i];
            end else if (sw_start[i]) begin
               run_reg[i] <= 1'b1;
            end else if (sw_stop[i]) begin
               run_reg[i] <= 1'b0;
            end
         end
      end
   endgenerate

   // Timer 0 start and stop sources; software has priority
   wire [1:0] src = cfg_reg[qtrc_pkg::CFG_SRC_LSB +: 2];
   wire [1:0] clk_sel = cfg_reg[qtrc_pkg::CFG_CLK_LSB +: 2];
   assign trim_mode = src[1];
   assign halt_ev = cfg_reg[qtrc_pkg::CFG_HALT_BIT] && !trim_mode && rx_nibble_done && run_reg[0];
   assign t0_start = sw_start[0]
                     || (src == qtrc_pkg::QTRC_SRC_TX_END && tx_done)
                     || (trim_mode && osc_rise && !run_reg[0]);
   assign t0_stop = sw_stop[0] || halt_ev || (trim_mode && osc_rise && run_reg[0]);

   always_comb begin
      case (clk_sel)
         qtrc_pkg::QTRC_CLK_FAST: tick0 = fast_tick_reg;
         qtrc_pkg::QTRC_CLK_SLOW: tick0 = slow_tick_reg;
         qtrc_pkg::QTRC_CLK_T2_UF: tick0 = uf_reg[2];
         qtrc_pkg::QTRC_CLK_T1_UF: tick0 = uf_reg[1];
         default: tick0 = 1'b0;
      endcase
   end
   // Trimming without underflow stops at zero with no flag
   assign uf0_allowed = (src != qtrc_pkg::QTRC_SRC_TRIM_NOUF);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt0_reg <= 16'h0000;
         run_reg[0] <= qtrc_pkg::RUN_RESET[0];
         uf_reg[0] <= 1'b0;
      end else begin
         uf_reg[0] <= 1'b0;
         if (sw_start[0] || (t0_start && !t0_stop)) begin
            cnt0_reg <= preset_reg;
            run_reg[0] <= 1'b1;
         end else if (t0_stop) begin
            run_reg[0] <= 1'b0;
         end else if (run_reg[0] && tick0) begin
            if (cnt0_reg == 16'h0000) begin
               if (!uf0_allowed) begin
                  run_reg[0] <= 1'b0;
               end else if (cfg_reg[qtrc_pkg::CFG_RESTART_BIT]) begin
                  cnt0_reg <= preset_reg;
                  uf_reg[0] <= 1'b1;
               end else begin
                  run_reg[0] <= 1'b0;
                  uf_reg[0] <= 1'b1;
               end
            end else begin
               cnt0_reg <= cnt0_reg - 16'h0001;
            end
         end
      end
   end

   // Sticky underflow flags; a new event beats a clear in the same cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         status_reg <= qtrc_pkg::IRQ_RESET;
      end else if (wr_pend_reg && wr_idx_reg == qtrc_pkg::IDX_IRQ_STATUS) begin
         status_reg <= (status_reg & ~wdata[3:0]) | uf_reg;
      end else begin
         status_reg <= status_reg | uf_reg;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(status_reg & mask_reg);
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   property p_mask_keeps;
      wr_ctrl && !wdata[1] |=> run_reg[1] == $past(run_reg[1]);
   endproperty
   a_mask_keeps: assert property (p_mask_keeps) else $error("Unmasked running bit changed");

   property p_all_start;
      wr_ctrl && wdata == 8'hff |=> run_reg == 4'hf;
   endproperty
   a_all_start: assert property (p_all_start) else $error("Write ff did not start all timers");

   property p_f0_noop;
      wr_ctrl && wdata == 8'hf0 && !uf_reg[0] && !t0_start && !t0_stop && !tick0
         |=> run_reg == $past(run_reg);
   endproperty
   a_f0_noop: assert property (p_f0_noop) else $error("Write f0 changed a running bit");

   property p_readback;
      addr_phase && !hwrite && reg_index(haddr) == qtrc_pkg::IDX_RUN_CTRL
         |=> hrdata[7:0] == {$past(run_reg), 4'h0};
   endproperty
   a_readback: assert property (p_readback) else $error("Run control readback wrong");

   property p_sw_start;
      sw_start[0] |=> run_reg[0] && cnt0_reg == $past(preset_reg);
   endproperty
   a_sw_start: assert property (p_sw_start) else $error("Software start did not load preset");

   property p_sw_stop;
      sw_stop[2] |=> !run_reg[2] ##1 !run_reg[2] || $past(sw_start[2]);
   endproperty
   a_sw_stop: assert property (p_sw_stop) else $error("Software stop ignored");

   property p_halt;
      halt_ev && !sw_start[0] |=> !run_reg[0];
   endproperty
   a_halt: assert property (p_halt) else $error("Halt on receive did not stop timer 0");

   property p_trim_no_halt;
      trim_mode && cfg_reg[qtrc_pkg::CFG_HALT_BIT] && rx_nibble_done && run_reg[0] && !osc_rise && !sw_stop[0]
         && !(tick0 && cnt0_reg == 16'h0000) |=> run_reg[0];
   endproperty
   a_trim_no_halt: assert property (p_trim_no_halt) else $error("Halt active during trimming");

   property p_tx_start;
      src == qtrc_pkg::QTRC_SRC_TX_END && tx_done && !sw_stop[0] && !halt_ev
         |=> run_reg[0] && cnt0_reg == $past(preset_reg);
   endproperty
   a_tx_start: assert property (p_tx_start) else $error("End of transmission did not start timer 0");

   property p_restart;
      run_reg[0] && tick0 && cnt0_reg == 16'h0000 && uf0_allowed && cfg_reg[3] && !t0_start && !t0_stop
         |=> run_reg[0] && uf_reg[0] ##1 status_reg[0];
   endproperty
   a_restart: assert property (p_restart) else $error("Reload on zero failed");

   property p_stop_zero;
      run_reg[0] && tick0 && cnt0_reg == 16'h0000 && !cfg_reg[3] && !t0_start && !t0_stop |=> !run_reg[0];
   endproperty
   a_stop_zero: assert property (p_stop_zero) else $error("Timer 0 kept running at zero");

   property p_flag;
      uf_reg[0] |=> status_reg[0];
   endproperty
   a_flag: assert property (p_flag) else $error("Underflow flag not set");

   property p_slow_spacing;
      slow_tick_reg |=> !slow_tick_reg [*8];
   endproperty
   a_slow_spacing: assert property (p_slow_spacing) else $error("Slow tick too frequent");

   property p_cascade;
      run_reg[0] && clk_sel == qtrc_pkg::QTRC_CLK_T2_UF && uf_reg[2] && cnt0_reg != 16'h0000
         && !t0_start && !t0_stop |=> cnt0_reg == $past(cnt0_reg) - 16'h0001;
   endproperty
   a_cascade: assert property (p_cascade) else $error("Cascade decrement missing");

   property p_reserved;
      cfg_reg[6] == 1'b0 && cfg_reg[2] == 1'b0;
   endproperty
   a_reserved: assert property (p_reserved) else $error("Reserved configuration bit set");

   c_restart: cover property (run_reg[0] && uf_reg[0] && cfg_reg[3]);
   c_halt: cover property (halt_ev);
   c_trim: cover property (trim_mode && osc_rise ##[1:300] trim_mode && osc_rise);
   c_irq: cover property (irq_reg);
endmodule : qtrc_top

// ==== hdl/qtrc_pkg.sv ====
package qtrc_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_RUN_CTRL = 8'h0e;
   localparam logic [7:0] IDX_T0_CFG = 8'h0f;
   localparam logic [7:0] IDX_PRESET_HI = 8'h10;
   localparam logic [7:0] IDX_PRESET_LO = 8'h11;
   localparam logic [7:0] IDX_COUNT_HI = 8'h12;
   localparam logic [7:0] IDX_COUNT_LO = 8'h13;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h20;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h21;

   // Field positions
   localparam int RUN_LSB = 4;
   localparam int CFG_HALT_BIT = 7;
   localparam int CFG_SRC_LSB = 4;
   localparam int CFG_RESTART_BIT = 3;
   localparam int CFG_CLK_LSB = 0;
   localparam logic [7:0] CFG_WRITABLE = 8'hbb;

   // Reset values
   localparam logic [3:0] RUN_RESET = 4'h0;
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [15:0] PRESET_RESET = 16'h0000;
   localparam logic [3:0] IRQ_RESET = 4'h0;

   typedef enum logic [1:0] {
      QTRC_SRC_NONE = 2'b00,
      QTRC_SRC_TX_END = 2'b01,
      QTRC_SRC_TRIM_NOUF = 2'b10,
      QTRC_SRC_TRIM_UF = 2'b11
   } qtrc_src_t;

   typedef enum logic [1:0] {
      QTRC_CLK_FAST = 2'b00,
      QTRC_CLK_SLOW = 2'b01,
      QTRC_CLK_T2_UF = 2'b10,
      QTRC_CLK_T1_UF = 2'b11
   } qtrc_clk_t;

   // Tick generation from the bus clock
   localparam int SYS_KHZ = 25000;
   localparam int FAST_KHZ = 13560;
   localparam int SLOW_HZ = 211875;
   localparam int SLOW_DIV = (FAST_KHZ * 1000) / SLOW_HZ;
endpackage : qtrc_pkg

// ==== verification/qtrc_top_tb_top.sv ====
`timescale 1ns/10ps
module qtrc_top_tb_top;
   localparam int LIMIT = 20000;
   localparam logic [7:0] RC = qtrc_pkg::IDX_RUN_CTRL;
   localparam logic [7:0] CF = qtrc_pkg::IDX_T0_CFG;
   localparam logic [7:0] PH = qtrc_pkg::IDX_PRESET_HI;
   localparam logic [7:0] PL = qtrc_pkg::IDX_PRESET_LO;
   localparam logic [7:0] IS = qtrc_pkg::IDX_IRQ_STATUS;
   localparam logic [7:0] IM = qtrc_pkg::IDX_IRQ_MASK;
   // Clock select, other timers running, allowed decrement window
   localparam logic [7:0] T_SEL [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h02, 8'h03};
   localparam logic [7:0] T_OTH [6] = '{8'h00, 8'h00, 8'h44, 8'h22, 8'h22, 8'h44};
   localparam logic [15:0] T_LO [6] = '{16'h008c, 16'h0001, 16'h001e, 16'h001e, 16'h0000, 16'h0000};
   localparam logic [15:0] T_HI [6] = '{16'h00be, 16'h0004, 16'h0032, 16'h0032, 16'h0000, 16'h0000};
   logic hclk;
   logic hresetn;
   logic hsel;
   logic hwrite;
   logic [31:0] haddr;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic hreadyout;
   logic hresp;
   logic tx_done;
   logic rx_nibble_done;
   logic osc;
   logic irq;
   logic [7:0] rd;
   logic [15:0] cnt;
   int num_errors;
   int checked;
   int cycles;
   int i;

   qtrc_top #(.OTHER_PRESET(16'h0003)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .tx_done(tx_done), .rx_nibble_done(rx_nibble_done),
      .low_frequency_oscillator(osc), .irq(irq));

   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : end_of_test

   always @(posedge hclk) begin
      cycles++;
      if (cycles == LIMIT) begin
         num_errors++;
         end_of_test();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic rng(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
      checked++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h to %h", $time, got, lo, hi);
      end
   endtask : rng

   task automatic bus(input logic [7:0] idx, input logic w, input logic [7:0] wd, output logic [7:0] r);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {22'h000000, idx, 2'b00};
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h000000, wd};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata[7:0];
   endtask : bus

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      bus(idx, 1'b1, d, rd);
   endtask : wr

   task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
      bus(idx, 1'b0, 8'h00, rd);
      chk({8'h00, rd}, {8'h00, exp});
   endtask : rdc

   task automatic rcnt;
      bus(qtrc_pkg::IDX_COUNT_HI, 1'b0, 8'h00, cnt[15:8]);
      bus(qtrc_pkg::IDX_COUNT_LO, 1'b0, 8'h00, cnt[7:0]);
   endtask : rcnt

   task automatic wait_n(input int n);
      repeat (n) @(posedge hclk);
   endtask : wait_n

   // Held four cycles so the two-flop synchroniser sees it
   task automatic osc_edge;
      @(posedge hclk);
      osc <= 1'b1;
      wait_n(4);
      osc <= 1'b0;
      wait_n(4);
   endtask : osc_edge

   task automatic pulse(input logic rx);
      @(posedge hclk);
      if (rx) rx_nibble_done <= 1'b1;
      else tx_done <= 1'b1;
      @(posedge hclk);
      rx_nibble_done <= 1'b0;
      tx_done <= 1'b0;
      wait_n(2);
   endtask : pulse

   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      hwrite = 1'b0;
      haddr = 32'h00000000;
      hwdata = 32'h00000000;
      htrans = 2'b00;
      hsize = 3'b010;
      tx_done = 1'b0;
      rx_nibble_done = 1'b0;
      osc = 1'b0;
      num_errors = 0;
      checked = 0;
      cycles = 0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      chk({15'h0000, irq}, 16'h0000);
      chk({15'h0000, hresp}, 16'h0000);
      rdc(RC, 8'h00);
      rdc(CF, 8'h00);
      rdc(8'h30, 8'h00);
      wr(CF, 8'hff);
      rdc(CF, 8'hbb);
      wr(CF, 8'h00);
      wr(PH, 8'h10);
      wr(RC, 8'hf0);
      rdc(RC, 8'h00);
      wr(RC, 8'hff);
      rdc(RC, 8'hf0);
      wr(RC, 8'h01);
      rdc(RC, 8'he0);
      wr(RC, 8'h0c);
      rdc(RC, 8'h20);
      wr(RC, 8'h12);
      rdc(RC, 8'h00);
      wr(IS, 8'h0f);
      rdc(IS, 8'h00);
      // Preset taken at a start event, not by a write while counting
      wr(CF, 8'h08);
      wr(PH, 8'h12);
      wr(PL, 8'h34);
      wr(RC, 8'h11);
      rcnt();
      rng(cnt, 16'h11f0, 16'h1234);
      wr(PH, 8'h05);
      rcnt();
      rng(cnt, 16'h1100, 16'h1234);
      wr(RC, 8'h01);
      wr(RC, 8'h11);
      rcnt();
      rng(cnt, 16'h04c0, 16'h0534);
      wr(RC, 8'h01);
      // One-shot and reload counts to zero, flag and interrupt
      wr(PH, 8'h00);
      wr(PL, 8'h10);
      wr(CF, 8'h00);
      wr(IM, 8'h01);
      rdc(IM, 8'h01);
      wr(RC, 8'h11);
      rd = 8'hff;
      for (i = 0; i < 50 && rd[4] !== 1'b0; i++) bus(RC, 1'b0, 8'h00, rd);
      chk({8'h00, rd}, 16'h0000);
      rdc(IS, 8'h01);
      wait_n(2);
      chk({15'h0000, irq}, 16'h0001);
      wr(IS, 8'h01);
      wait_n(2);
      chk({15'h0000, irq}, 16'h0000);
      rdc(IS, 8'h00);
      wr(CF, 8'h08);
      wr(RC, 8'h11);
      wait_n(200);
      rdc(RC, 8'h10);
      rdc(IS, 8'h01);
      wr(RC, 8'h01);
      wr(IS, 8'h01);
      // Automatic start sources and halt on receive
      wr(CF, 8'h18);
      pulse(1'b0);
      rdc(RC, 8'h10);
      wr(RC, 8'h01);
      wr(CF, 8'h08);
      pulse(1'b0);
      rdc(RC, 8'h00);
      wr(PH, 8'hff);
      wr(CF, 8'h88);
      wr(RC, 8'h11);
      pulse(1'b1);
      rdc(RC, 8'h00);
      wr(CF, 8'h08);
      wr(RC, 8'h11);
      pulse(1'b1);
      rdc(RC, 8'h10);
      wr(RC, 8'h01);
      // Trimming: oscillator edges start and stop, receive halt ignored
      wr(CF, 8'ha8);
      osc_edge();
      rdc(RC, 8'h10);
      pulse(1'b1);
      rdc(RC, 8'h10);
      osc_edge();
      rdc(RC, 8'h00);
      wr(PH, 8'h00);
      wr(PL, 8'h08);
      wr(CF, 8'h28);
      wr(IS, 8'h0f);
      osc_edge();
      wait_n(60);
      rdc(RC, 8'h00);
      rdc(IS, 8'h00);
      wr(CF, 8'h38);
      osc_edge();
      wait_n(60);
      rdc(IS, 8'h01);
      rdc(RC, 8'h10);
      osc_edge();
      wr(IS, 8'h0f);
      // Count clock sources, cascades checked against a stopped source too
      wr(PH, 8'h10);
      wr(PL, 8'h00);
      for (i = 0; i < 6; i++) begin
         wr(RC, 8'h0f);
         wr(CF, 8'h08 | T_SEL[i]);
         wr(RC, T_OTH[i]);
         wr(RC, 8'h11);
         wait_n(300);
         rcnt();
         rng(16'h1000 - cnt, T_LO[i], T_HI[i]);
      end
      wr(RC, 8'h0f);
      end_of_test();
   end
endmodule : qtrc_top_tb_top
